/* logic/sldc_regs.vh */
// Register offsets, field positions and reset values of the switch link debug and configuration bank.
`ifndef SLDC_REGS_VH
`define SLDC_REGS_VH
`define SLDC_IDX_DBG_CFG0    8'h10
`define SLDC_IDX_DBG_CFG1    8'h11
`define SLDC_IDX_DBG_SRC     8'h1f
`define SLDC_IDX_LSTAT_BASE  8'h20
`define SLDC_IDX_LSTAT_LAST  8'h28
`define SLDC_IDX_PSTAT_BASE  8'h40
`define SLDC_IDX_PSTAT_LAST  8'h47
`define SLDC_IDX_XCFG_BASE   8'h80
`define SLDC_IDX_XCFG_LAST   8'h88
`define SLDC_IDX_SFWD_BASE   8'ha0
`define SLDC_IDX_SFWD_LAST   8'ha7
`define SLDC_DBG_REQ_EN      1
`define SLDC_DBG_DRIVE_EN    0
`define SLDC_SRC_PIN         4
`define SLDC_SRC_CORE1       1
`define SLDC_SRC_CORE0       0
`define SLDC_XCFG_ENABLE     31
`define SLDC_XCFG_FIVE_WIRE  30
`define SLDC_XCFG_ERROR      27
`define SLDC_XCFG_CRED_OUT   26
`define SLDC_XCFG_CRED_IN    25
`define SLDC_XCFG_CREDIT_INIT_TOKEN      24
`define SLDC_XCFG_RX_RESET   23
`define SLDC_SFWD_ENABLE     31
`define SLDC_SFWD_PROC       8
`define SLDC_RESET_VALUE     32'h0000_0000
`define SLDC_UNMAPPED_VALUE  32'h0000_0000
`endif

/* logic/sldc_bank.v */
// Control and status register bank of the message switch: debug line, link status, link config, static forwarding.
`timescale 1ns/1ps
// Overview of operation
// - Tile debug config bit 1 lets the shared debug line request debug of its core.
// - Tile debug config bit 0 lets the core halted flag drive the shared debug line.
// - Debug source bit 4 set when the external pin caused the last debug event.
// - Debug source bits 1 and 0 show which core caused the last debug event.
// - Link status bits 25:24 read the kind of target sourcing the link.
// - Link status bits 23:16 read the destination link number while in use.
// - External link status bits 11:8 hold a writable direction, reset zero.
// - External and processor link status bits 5:4 hold a writable network number.
// - Link status bit 2 reads one while the current packet is junk.
// - Link status bits 1 and 0 read destination side and source side busy.
// - Config bit 31 enables or disables the external link and selects pin muxing.
// - Config bit 30 selects two wire (0) or five wire (1) mode, reset zero.
// - Config bit 27 flags receive overflow or illegal token encoding.
// - Config bit 26 reads that local end has issued credit to the remote end.
// - Config bit 25 reads that local end holds credit; send only with credit.
// - Writing one to config bit 24 clears local credit and sends a greeting token.
// - Writing one to config bit 23 resets the receiver to start a new token.
// - Config bits 21:11 hold minimum idle clocks between symbols, minus one.
// - Config bits 10:0 hold minimum idle clocks between tokens, minus one.
// - Static forwarding enable sends all received traffic to a local channel end.
// - Static config holds destination processor bit 8 and channel end bits 4:0.
// - Static config registers in order map to links C, D, A, B, G, H, E, F.
`include "sldc_regs.vh"
module sldc_bank #(
  parameter NXL = 9,
  parameter NPL = 8,
  parameter NSF = 8
) (
  input  wire                 clk,
  input  wire                 nrst,
  input  wire [9:0]           avs_address,
  input  wire                 avs_read,
  input  wire                 avs_write,
  input  wire [31:0]          avs_writedata,
  input  wire [3:0]           avs_byteenable,
  output reg  [31:0]          avs_readdata,
  output wire                 avs_waitrequest,
  input  wire                 debug_pin_in_n,
  output wire                 debug_pin_oe_n,
  input  wire [1:0]           core_halted_flag,
  output wire [1:0]           core_debug_req,
  input  wire [2*NXL-1:0]     xl_src_kind,
  input  wire [8*NXL-1:0]     xl_dest_link,
  input  wire [NXL-1:0]       xl_junk,
  input  wire [NXL-1:0]       xl_dest_busy,
  input  wire [NXL-1:0]       xl_src_busy,
  input  wire [2*NPL-1:0]     pl_src_kind,
  input  wire [8*NPL-1:0]     pl_dest_link,
  input  wire [NPL-1:0]       pl_junk,
  input  wire [NPL-1:0]       pl_dest_busy,
  input  wire [NPL-1:0]       pl_src_busy,
  input  wire [NXL-1:0]       xl_rx_overflow,
  input  wire [NXL-1:0]       xl_rx_bad_token,
  input  wire [NXL-1:0]       xl_credit_issued_set,
  input  wire [NXL-1:0]       xl_credit_held_set,
  output wire [NXL-1:0]       xl_enable,
  output wire [NXL-1:0]       xl_five_wire,
  output wire [4*NXL-1:0]     xl_direction,
  output wire [2*NXL-1:0]     xl_network,
  output wire [2*NPL-1:0]     pl_network,
  output wire [11*NXL-1:0]    xl_symbol_gap,
  output wire [11*NXL-1:0]    xl_token_gap,
  output reg  [NXL-1:0]       xl_send_credit_init_token,
  output reg  [NXL-1:0]       xl_rx_reset,
  output wire [NXL-1:0]       xl_tx_allowed,
  output wire [NSF-1:0]       sf_enable,
  output wire [NSF-1:0]       sf_dest_proc,
  output wire [5*NSF-1:0]     sf_dest_chanend
);

  reg  [1:0]       dbg_cfg0_ff;
  reg  [1:0]       dbg_cfg1_ff;
  reg  [2:0]       dbg_src_ff;
  reg              pin_s1_ff;
  reg              pin_s2_ff;
  reg              line_prev_ff;
  reg  [NXL-1:0]   xen_ff;
  reg  [NXL-1:0]   xfive_ff;
  reg  [NXL-1:0]   xerr_ff;
  reg  [NXL-1:0]   xcred_out_ff;
  reg  [NXL-1:0]   xcred_in_ff;
  reg  [4*NXL-1:0] xdir_ff;
  reg  [2*NXL-1:0] xnet_ff;
  reg  [2*NPL-1:0] pnet_ff;
  reg  [11*NXL-1:0] xsym_ff;
  reg  [11*NXL-1:0] xtok_ff;
  reg  [NSF-1:0]   sen_ff;
  reg  [NSF-1:0]   sproc_ff;
  reg  [5*NSF-1:0] schan_ff;
  reg              rd_done_ff;

  wire [7:0]  idx  = avs_address[9:2];
  wire        wr   = avs_write;
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wd   = avs_writedata & be_mask;

  // Writes complete at once; a read waits one cycle so that read data comes from a flip-flop.
  assign avs_waitrequest = avs_read & ~rd_done_ff;

  // Shared debug line: pin low, or any enabled halted core driving it.
  wire core0_drive = core_halted_flag[0] & dbg_cfg0_ff[`SLDC_DBG_DRIVE_EN];
  wire core1_drive = core_halted_flag[1] & dbg_cfg1_ff[`SLDC_DBG_DRIVE_EN];
  wire pin_active  = ~pin_s2_ff;
  wire shared_debug_line = pin_active | core0_drive | core1_drive;
  // The pin is open drain; its output is pulled low while the enable is low.
  assign debug_pin_oe_n = ~(core0_drive | core1_drive);
  assign core_debug_req[0] = shared_debug_line & dbg_cfg0_ff[`SLDC_DBG_REQ_EN];
  assign core_debug_req[1] = shared_debug_line & dbg_cfg1_ff[`SLDC_DBG_REQ_EN];
  wire debug_event = shared_debug_line & ~line_prev_ff;

  assign xl_enable     = xen_ff;
  assign xl_five_wire  = xfive_ff;
  assign xl_direction  = xdir_ff;
  assign xl_network    = xnet_ff;
  assign pl_network    = pnet_ff;
  assign xl_symbol_gap = xsym_ff;
  assign xl_token_gap  = xtok_ff;
  assign xl_tx_allowed = xcred_in_ff & xen_ff;
  assign sf_enable       = sen_ff;
  assign sf_dest_proc    = sproc_ff;
  assign sf_dest_chanend = schan_ff;

  integer i;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dbg_cfg0_ff   <= 2'h0;
      dbg_cfg1_ff   <= 2'h0;
      dbg_src_ff    <= 3'h0;
      pin_s1_ff     <= 1'b1;
      pin_s2_ff     <= 1'b1;
      line_prev_ff  <= 1'b0;
      xen_ff        <= {NXL{1'b0}};
      xfive_ff      <= {NXL{1'b0}};
      xerr_ff       <= {NXL{1'b0}};
      xcred_out_ff  <= {NXL{1'b0}};
      xcred_in_ff   <= {NXL{1'b0}};
      xdir_ff       <= {4*NXL{1'b0}};
      xnet_ff       <= {2*NXL{1'b0}};
      pnet_ff       <= {2*NPL{1'b0}};
      xsym_ff       <= {11*NXL{1'b0}};
      xtok_ff       <= {11*NXL{1'b0}};
      sen_ff        <= {NSF{1'b0}};
      sproc_ff      <= {NSF{1'b0}};
      schan_ff      <= {5*NSF{1'b0}};
      xl_send_credit_init_token <= {NXL{1'b0}};
      xl_rx_reset   <= {NXL{1'b0}};
      rd_done_ff    <= 1'b0;
      avs_readdata  <= `SLDC_RESET_VALUE;
    end else begin
      pin_s1_ff    <= debug_pin_in_n;
      pin_s2_ff    <= pin_s1_ff;
      line_prev_ff <= shared_debug_line;
      xl_send_credit_init_token <= {NXL{1'b0}};
      xl_rx_reset   <= {NXL{1'b0}};
      rd_done_ff   <= avs_read & ~rd_done_ff;

      // Software writes first; hardware events below take precedence in the same cycle.
      if (wr) begin
        if (idx == `SLDC_IDX_DBG_CFG0 && avs_byteenable[0])
          dbg_cfg0_ff <= avs_writedata[1:0];
        if (idx == `SLDC_IDX_DBG_CFG1 && avs_byteenable[0])
          dbg_cfg1_ff <= avs_writedata[1:0];
        if (idx == `SLDC_IDX_DBG_SRC && avs_byteenable[0])
          dbg_src_ff <= {avs_writedata[`SLDC_SRC_PIN], avs_writedata[`SLDC_SRC_CORE1:`SLDC_SRC_CORE0]};
      end
      for (i = 0; i < NXL; i = i + 1) begin
        if (wr && idx == `SLDC_IDX_LSTAT_BASE + i[7:0]) begin
          if (avs_byteenable[1])
            xdir_ff[4*i +: 4] <= avs_writedata[11:8];
          if (avs_byteenable[0])
            xnet_ff[2*i +: 2] <= avs_writedata[5:4];
        end
        if (wr && idx == `SLDC_IDX_XCFG_BASE + i[7:0]) begin
          if (avs_byteenable[3]) begin
            xen_ff[i]   <= avs_writedata[`SLDC_XCFG_ENABLE];
            xfive_ff[i] <= avs_writedata[`SLDC_XCFG_FIVE_WIRE];
          end
          xsym_ff[11*i +: 11] <= (wd[21:11] & be_mask[21:11]) | (xsym_ff[11*i +: 11] & ~be_mask[21:11]);
          xtok_ff[11*i +: 11] <= (wd[10:0] & be_mask[10:0]) | (xtok_ff[11*i +: 11] & ~be_mask[10:0]);
          if (wd[`SLDC_XCFG_CREDIT_INIT_TOKEN])
            xl_send_credit_init_token[i] <= 1'b1;
          if (wd[`SLDC_XCFG_RX_RESET]) begin
            xl_rx_reset[i] <= 1'b1;
            xerr_ff[i]     <= 1'b0;
          end
        end
        // Credit: greeting write clears held credit, remote credit sets it; set wins.
        if (xl_credit_held_set[i])
          xcred_in_ff[i] <= 1'b1;
        else if (wr && idx == `SLDC_IDX_XCFG_BASE + i[7:0] && wd[`SLDC_XCFG_CREDIT_INIT_TOKEN])
          xcred_in_ff[i] <= 1'b0;
        if (xl_credit_issued_set[i])
          xcred_out_ff[i] <= 1'b1;
        else if (!xen_ff[i])
          xcred_out_ff[i] <= 1'b0;
        if (xl_rx_overflow[i] | xl_rx_bad_token[i])
          xerr_ff[i] <= 1'b1;
      end
      for (i = 0; i < NPL; i = i + 1) begin
        if (wr && idx == `SLDC_IDX_PSTAT_BASE + i[7:0] && avs_byteenable[0])
          pnet_ff[2*i +: 2] <= avs_writedata[5:4];
      end
      for (i = 0; i < NSF; i = i + 1) begin
        // Index order C, D, A, B, G, H, E, F is carried by port order of sf_*.
        if (wr && idx == `SLDC_IDX_SFWD_BASE + i[7:0]) begin
          if (avs_byteenable[3])
            sen_ff[i] <= avs_writedata[`SLDC_SFWD_ENABLE];
          if (avs_byteenable[1])
            sproc_ff[i] <= avs_writedata[`SLDC_SFWD_PROC];
          if (avs_byteenable[0])
            schan_ff[5*i +: 5] <= avs_writedata[4:0];
        end
      end
      if (debug_event) begin
        dbg_src_ff <= {pin_active, core1_drive, core0_drive};
      end

      if (avs_read && !rd_done_ff) begin
        avs_readdata <= `SLDC_UNMAPPED_VALUE;
        if (idx == `SLDC_IDX_DBG_CFG0)
          avs_readdata <= {30'h0000_0000, dbg_cfg0_ff};
        if (idx == `SLDC_IDX_DBG_CFG1)
          avs_readdata <= {30'h0000_0000, dbg_cfg1_ff};
        if (idx == `SLDC_IDX_DBG_SRC)
          avs_readdata <= {27'h000_0000, dbg_src_ff[2], 2'h0, dbg_src_ff[1:0]};
        for (i = 0; i < NXL; i = i + 1) begin
          if (idx == `SLDC_IDX_LSTAT_BASE + i[7:0])
            avs_readdata <= {6'h00, xl_src_kind[2*i +: 2], xl_dest_link[8*i +: 8], 4'h0,
                             xdir_ff[4*i +: 4], 2'h0, xnet_ff[2*i +: 2], 1'b0,
                             xl_junk[i], xl_dest_busy[i], xl_src_busy[i]};
          if (idx == `SLDC_IDX_XCFG_BASE + i[7:0])
            avs_readdata <= {xen_ff[i], xfive_ff[i], 2'h0, xerr_ff[i], xcred_out_ff[i], xcred_in_ff[i],
                             3'h0, xsym_ff[11*i +: 11], xtok_ff[11*i +: 11]};
        end
        for (i = 0; i < NPL; i = i + 1) begin
          if (idx == `SLDC_IDX_PSTAT_BASE + i[7:0])
            avs_readdata <= {6'h00, pl_src_kind[2*i +: 2], pl_dest_link[8*i +: 8], 10'h000,
                             pnet_ff[2*i +: 2], 1'b0, pl_junk[i], pl_dest_busy[i], pl_src_busy[i]};
        end
        for (i = 0; i < NSF; i = i + 1) begin
          if (idx == `SLDC_IDX_SFWD_BASE + i[7:0])
            avs_readdata <= {sen_ff[i], 22'h00_0000, sproc_ff[i], 3'h0, schan_ff[5*i +: 5]};
        end
      end
    end
  end

endmodule

/* verif/sldc_bank_monitor.sv */
// Port checker of the switch link debug and configuration bank.
`timescale 1ns/1ps
module sldc_bank_monitor #(parameter NXL = 9, parameter NSF = 8) (
  input wire              clk,
  input wire              nrst,
  input wire [9:0]        avs_address,
  input wire              avs_read,
  input wire              avs_write,
  input wire [31:0]       avs_writedata,
  input wire [3:0]        avs_byteenable,
  input wire [31:0]       avs_readdata,
  input wire              avs_waitrequest,
  input wire              debug_pin_oe_n,
  input wire [1:0]        core_halted_flag,
  input wire [NXL-1:0]    xl_enable,
  input wire [NXL-1:0]    xl_send_credit_init_token,
  input wire [NXL-1:0]    xl_tx_allowed,
  input wire [11*NXL-1:0] xl_token_gap,
  input wire [NSF-1:0]    sf_enable,
  input wire [5*NSF-1:0]  sf_dest_chanend
);
  wire x0 = avs_write && avs_address[9:2] == 8'h80;
  wire s0 = avs_write && avs_address[9:2] == 8'ha0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  credit_init_token_pulse_a: assert property (xl_send_credit_init_token[0] == $past(x0 && avs_byteenable[3] && avs_writedata[24]))
    else $error("greeting pulse wrong");
  link_enable_a: assert property (x0 && avs_byteenable[3] |=> xl_enable[0] == $past(avs_writedata[31]))
    else $error("link enable not written");
  token_gap_a: assert property (x0 && avs_byteenable[1:0] == 2'h3 |=> xl_token_gap[10:0] == $past(avs_writedata[10:0]))
    else $error("token gap not written");
  static_enable_a: assert property (s0 && avs_byteenable[3] |=> sf_enable[0] == $past(avs_writedata[31]))
    else $error("static enable not written");
  static_chanend_a: assert property (s0 && avs_byteenable[0] |=> sf_dest_chanend[4:0] == $past(avs_writedata[4:0]))
    else $error("channel end not written");
  send_credit_a: assert property (xl_tx_allowed[0] |-> xl_enable[0])
    else $error("send allowed on disabled link");
  pin_drive_a: assert property (!debug_pin_oe_n |-> core_halted_flag != 2'h0)
    else $error("debug pin pulled with no halted core");
  reserved_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[9:2] == 8'h10 |=> avs_readdata[31:2] == 30'h0000_0000)
    else $error("reserved bits not zero");
endmodule
bind sldc_bank sldc_bank_monitor #(.NXL(NXL), .NSF(NSF)) u_mon (.clk(clk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .debug_pin_oe_n(debug_pin_oe_n),
  .core_halted_flag(core_halted_flag), .xl_enable(xl_enable), .xl_send_credit_init_token(xl_send_credit_init_token),
  .xl_tx_allowed(xl_tx_allowed), .xl_token_gap(xl_token_gap), .sf_enable(sf_enable), .sf_dest_chanend(sf_dest_chanend));

/* verif/sldc_remote_link.sv */
// Remote switch model: answers a greeting token on link 0 by granting credit after a set delay.
`timescale 1ns/1ps
module sldc_remote_link (
  input  wire       clk,
  input  wire       nrst,
  input  wire       credit_init_token,
  input  wire [3:0] delay,
  output reg        credit_set
);
  reg [4:0] cnt_ff;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff     <= 5'h0;
      credit_set <= 1'b0;
    end else begin
      credit_set <= (cnt_ff == 5'h1);
      if (credit_init_token) begin
        cnt_ff <= {1'b0, delay} + 5'h1;
      end else if (cnt_ff != 5'h0) begin
        cnt_ff <= cnt_ff - 5'h1;
      end
    end
  end
endmodule

/* verif/tb_sldc_bank.sv */
// Random and corner-case bench for the switch link debug and configuration bank.
`timescale 1ns/1ps
module tb_sldc_bank;
  reg  [9:0]  adr;
  reg         clk, nrst, rd, wr, ext_low;
  reg  [31:0] wd, d, q;
  reg  [3:0]  be, dly;
  reg  [1:0]  halted;
  reg  [17:0] kind;
  reg  [71:0] dest;
  reg  [8:0]  junk, dbsy, sbsy, ovf, iss;
  wire [31:0] rdata;
  wire [8:0]  credit_init_token, txok;
  wire [7:0]  sfen;
  wire [39:0] sfch;
  wire [1:0]  creq;
  wire        wreq, oe_n, cset;
  wire        pin_n = oe_n & ~ext_low;
  integer     seed, fails, checked, k, j;
  localparam [47:0] RL = 48'h1011_80a0_20ff;
  always #2 clk = ~clk;
  sldc_bank DUT (.clk(clk), .nrst(nrst), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq), .debug_pin_in_n(pin_n), .debug_pin_oe_n(oe_n),
    .core_halted_flag(halted), .core_debug_req(creq), .xl_src_kind(kind), .xl_dest_link(dest), .xl_junk(junk),
    .xl_dest_busy(dbsy), .xl_src_busy(sbsy), .pl_src_kind(kind[15:0]), .pl_dest_link(dest[63:0]), .pl_junk(junk[7:0]),
    .pl_dest_busy(dbsy[7:0]), .pl_src_busy(sbsy[7:0]), .xl_rx_overflow(ovf), .xl_rx_bad_token({ovf[7:0], ovf[8]}),
    .xl_credit_issued_set(iss), .xl_credit_held_set({iss[8:1], cset}), .xl_enable(), .xl_five_wire(),
    .xl_direction(), .xl_network(), .pl_network(), .xl_symbol_gap(), .xl_token_gap(), .xl_send_credit_init_token(credit_init_token),
    .xl_rx_reset(), .xl_tx_allowed(txok), .sf_enable(sfen), .sf_dest_proc(), .sf_dest_chanend(sfch));
  sldc_remote_link u_far (.clk(clk), .nrst(nrst), .credit_init_token(credit_init_token[0]), .delay(dly), .credit_set(cset));
  function [31:0] lstat(input integer i, input [31:0] w, input ext);
    lstat = {6'h0, kind[2*i+:2], dest[8*i+:8], 4'h0, ext ? w[11:8] : 4'h0, 2'h0, w[5:4], 1'b0, junk[i], dbsy[i], sbsy[i]};
  endfunction
  task check(input [8*6-1:0] what, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Holds the request until waitrequest is sampled low at a rising edge, takes read data there, then idles a cycle.
  task bus(input w, input [7:0] i, input [31:0] v, input [3:0] b, output [31:0] r);
    begin
      adr <= {i, 2'h0};
      rd <= ~w;
      wr <= w;
      wd <= v;
      be <= b;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    {clk, nrst, adr, rd, wr, wd, be, ext_low, halted, dly, kind, dest, junk, dbsy, sbsy, ovf, iss} = 0;
    {seed, fails, checked} = {32'hb395, 64'h0};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 6; k = k + 1) begin
      bus(1'b0, RL[8*k+:8], 32'h0, 4'hf, q);
      check("reset", q, 32'h0);
    end
    bus(1'b1, 8'hff, 32'hffff_ffff, 4'hf, q);
    bus(1'b0, 8'hff, 32'h0, 4'hf, q);
    check("unmap", q, 32'h0);
    for (k = 0; k < 8; k = k + 1) begin
      d = $random(seed);
      bus(1'b1, {5'h14, k[2:0]}, d, 4'hf, q);
      bus(1'b1, {5'h14, k[2:0]}, ~d, 4'h1, q);
      bus(1'b0, {5'h14, k[2:0]}, 32'h0, 4'hf, q);
      d = (d & 32'h8000_0100) | (~d & 32'h0000_001f);
      check("static", q, d);
      check("sf_out", {sfen[k[2:0]], sfch[5*k+:5]}, {d[31], d[4:0]});
      q = $random(seed);
      kind <= q[17:0];
      dest <= {dest[39:0], q};
      junk <= q[26:18];
      dbsy <= q[8:0] ^ q[31:23];
      sbsy <= ~q[8:0];
      bus(1'b1, {5'h04, k[2:0]}, d, 4'hf, q);
      bus(1'b0, {5'h04, k[2:0]}, 32'h0, 4'hf, q);
      check("xlstat", q, lstat(k, d, 1'b1));
      bus(1'b1, {5'h08, k[2:0]}, d, 4'hf, q);
      bus(1'b0, {5'h08, k[2:0]}, 32'h0, 4'hf, q);
      check("plstat", q, lstat(k, d, 1'b0));
    end
    for (j = 0; j < 2; j = j + 1) begin
      dly <= j[0] ? 4'hf : 4'h0;
      d = ($random(seed) & 32'hc03f_ffff) | 32'h8100_0000;
      bus(1'b1, 8'h80, d, 4'hf, q);
      if (j == 1) check("nocred", txok[0], 1'b0);
      for (k = 0; k < 40 && txok[0] !== 1'b1; k = k + 1) @(posedge clk);
      check("txok", txok[0], 1'b1);
      iss <= 9'h001;
      ovf <= 9'h001;
      @(posedge clk);
      {iss, ovf} <= 18'h0;
      bus(1'b0, 8'h80, 32'h0, 4'hf, q);
      check("xcfg", q, (d & 32'hc03f_ffff) | 32'h0e00_0000);
      bus(1'b1, 8'h80, d ^ 32'h0180_0000, 4'hf, q);
      bus(1'b0, 8'h80, 32'h0, 4'hf, q);
      check("rxrst", q, (d & 32'hc03f_ffff) | 32'h0600_0000);
    end
    bus(1'b1, 8'h10, 32'hffff_ffff, 4'hf, q);
    bus(1'b0, 8'h10, 32'h0, 4'hf, q);
    check("dbgcfg", q, 32'h0000_0003);
    bus(1'b1, 8'h11, 32'h0000_0002, 4'hf, q);
    halted <= 2'h1;
    repeat (4) @(posedge clk);
    check("oe_n", oe_n, 1'b0);
    check("dbgreq", creq, 2'h3);
    halted <= 2'h0;
    bus(1'b0, 8'h1f, 32'h0, 4'hf, q);
    check("coresrc", q & 32'h0000_0003, 32'h0000_0001);
    bus(1'b1, 8'h1f, 32'h0, 4'hf, q);
    ext_low <= 1'b1;
    repeat (4) @(posedge clk);
    ext_low <= 1'b0;
    bus(1'b0, 8'h1f, 32'h0, 4'hf, q);
    check("pinsrc", q & 32'h0000_0013, 32'h0000_0010);
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails = fails + 1;
    tally_and_finish;
  end
endmodule
